//--- tb/rss_board_model.sv
module rss_board_model (
    input wire logic clk_sys, // System clock.
    input wire logic auto_cmd, // Board selects automatic mode.
    input wire logic latch_cmd, // Board holds the latch pin high.
    input wire logic [1:0] rate_cmd, // Index the board drives in manual mode.
    input wire logic search_request, // Request from the device.
    input wire logic [1:0] bus_out, // Device drive values.
    input wire logic [1:0] bus_oe, // Device drive enables.
    output logic auto_mode, // Mode pin.
    output logic search_latch_enable, // Latch pin.
    output logic [1:0] bus_pin // Resolved rate bus level.
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] last_reg;

    assign auto_mode = auto_cmd;
    // The request loops back only in automatic mode; the board may also hold the pin itself.
    assign search_latch_enable = latch_cmd | (auto_cmd & search_request);
    // The bus has no pull, so in automatic mode an undriven line shows the inverse of its last level; in manual mode it shows rate_cmd.
    assign bus_pin = (bus_oe & bus_out) | (~bus_oe & (!auto_cmd ? rate_cmd : ~last_reg));

    always_ff @(posedge clk_sys) begin
        last_reg <= bus_pin;
    end
endmodule

//--- tb/rss_rate_search_unit_tb.sv
module rss_rate_search_unit_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import rss_pkg::*;
    localparam int PER = 8;
    logic clk_sys = 1'h0;
    logic rst = 1'h1;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'h0, avs_write = 1'h0, avs_waitrequest;
    logic [31:0] avs_writedata = 32'h0, avs_readdata;
    logic auto_cmd = 1'h0, latch_cmd = 1'h0, mute_n = 1'h1, sdi = 1'h0, data_on = 1'h0;
    logic unlock = 1'h0, harm = 1'h0, rclk = 1'h0, rdat = 1'h0;
    logic [1:0] rate_cmd = 2'h0;
    wire logic [1:0] bus_out, bus_oe, bus_pin;
    logic auto_mode, sle, rco, rdo, present, req, irq;
    int fails = 0, n_checks = 0, tgl = 0;

    initial begin
        forever #5 clk_sys = ~clk_sys;
    end

    // Transitions every 20 cycles keep the carrier well inside its window.
    always @(posedge clk_sys) begin
        tgl <= (tgl == 19) ? 0 : tgl + 1;
        if (data_on && tgl == 19) begin
            sdi <= ~sdi;
        end
    end

    rss_board_model u_board (.clk_sys(clk_sys), .auto_cmd(auto_cmd), .latch_cmd(latch_cmd),
        .rate_cmd(rate_cmd), .search_request(req), .bus_out(bus_out), .bus_oe(bus_oe),
        .auto_mode(auto_mode), .search_latch_enable(sle), .bus_pin(bus_pin));

    rss_rate_search_unit #(.STEP_PERIOD_CYC(PER)) u_dut (.clk_sys(clk_sys), .rst(rst),
        .clk_en(1'h1), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .auto_mode(auto_mode), .search_latch_enable(sle),
        .mute_n(mute_n), .serial_data_in(sdi), .freq_unlock_flag(unlock),
        .harmonic_lock_flag(harm), .recovered_clock_in(rclk), .retimed_data_in(rdat),
        .rate_bit_low_in(bus_pin[0]), .rate_bit_low_out(bus_out[0]), .rate_bit_low_oe(bus_oe[0]),
        .rate_bit_high_in(bus_pin[1]), .rate_bit_high_out(bus_out[1]),
        .rate_bit_high_oe(bus_oe[1]), .recovered_clock_out(rco), .retimed_data_out(rdo),
        .signal_present(present), .search_request(req), .irq(irq));

    task automatic print_verdict();
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys);
    endtask

    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        int n;
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= !wr;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'h0 && n < 50);
        rd = avs_readdata;
        avs_write <= 1'h0;
        avs_read <= 1'h0;
        if (n >= 50) begin
            fails++;
            print_verdict();
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] t;
        bus(1'h1, a, d, t);
    endtask

    task automatic rdchk(input string name, input logic [4:0] a, input logic [31:0] exp);
        logic [31:0] t;
        bus(1'h0, a, 32'h0, t);
        chk(name, exp, t);
    endtask

    task automatic t_reset();
        rdchk("ctrl", RSS_ADDR_CTRL, 32'h1);
        rdchk("status", RSS_ADDR_STATUS, 32'h0);
        rdchk("period", RSS_ADDR_PERIOD, PER);
        rdchk("mask", RSS_ADDR_IRQ_MASK, 32'h0);
        rdchk("unmapped", 5'h14, 32'h0);
        wr(5'h14, 32'hFFFFFFFF);
        rdchk("ctrl kept", RSS_ADDR_CTRL, 32'h1);
    endtask

    task automatic t_carrier();
        data_on <= 1'h1;
        cyc(30);
        chk("present", 1, present);
        repeat (5) begin
            cyc(40);
            chk("present held", 1, present);
        end
        data_on <= 1'h0;
        cyc(130);
        chk("present gone", 0, present);
    endtask

    task automatic t_request();
        data_on <= 1'h1;
        cyc(30);
        for (int c = 0; c < 4; c++) begin
            unlock <= c[1];
            harm <= c[0];
            cyc(4);
            chk("request", c != 0, req);
        end
        data_on <= 1'h0;
        cyc(130);
        chk("request no carrier", 0, req);
        unlock <= 1'h0;
        harm <= 1'h0;
    endtask

    task automatic t_auto();
        logic [1:0] prev;
        logic [1:0] nx;
        int last;
        int steps;
        wr(RSS_ADDR_PERIOD, 32'h6);
        wr(RSS_ADDR_IRQ_MASK, 32'h1);
        auto_cmd <= 1'h1;
        data_on <= 1'h1;
        cyc(30);
        unlock <= 1'h1;
        prev = bus_pin;
        last = 0;
        steps = 0;
        for (int k = 1; k < 200 && steps < 6; k++) begin
            @(posedge clk_sys);
            if (bus_pin !== prev) begin
                steps++;
                nx = prev + 2'h1;
                chk("step value", nx, bus_pin);
                if (steps > 1) chk("step interval", 6, k - last);
                prev = bus_pin;
                last = k;
            end
        end
        chk("steps", 6, steps);
        chk("drive enable", 2'h3, bus_oe);
        chk("irq step", 1, irq);
        unlock <= 1'h0;
        cyc(4);
        prev = bus_pin;
        cyc(30);
        chk("hold after lock", prev, bus_pin);
        rdchk("status auto", RSS_ADDR_STATUS, 32'h14 | prev);
        // Holding the latch pin without carrier must still not step.
        latch_cmd <= 1'h1;
        data_on <= 1'h0;
        cyc(130);
        prev = bus_pin;
        cyc(30);
        chk("no step without carrier", prev, bus_pin);
        latch_cmd <= 1'h0;
        wr(RSS_ADDR_IRQ_MASK, 32'h0);
        cyc(3);
        chk("irq masked", 0, irq);
        wr(RSS_ADDR_IRQ_STATUS, 32'hF);
        rdchk("irq cleared", RSS_ADDR_IRQ_STATUS, 32'h0);
    endtask

    task automatic t_manual();
        auto_cmd <= 1'h0;
        for (int i = 0; i < 4; i++) begin
            rate_cmd <= 2'(i);
            cyc(2);
            latch_cmd <= 1'h1;
            cyc(2);
            latch_cmd <= 1'h0;
            rate_cmd <= ~2'(i);
            cyc(3);
            rdchk("manual rate", RSS_ADDR_STATUS, i);
            chk("bus released", 2'h0, bus_oe);
        end
    endtask

    task automatic t_mute();
        rclk <= 1'h1;
        rdat <= 1'h1;
        cyc(3);
        chk("clock pass", 1, rco);
        mute_n <= 1'h0;
        cyc(2);
        rclk <= 1'h0;
        rdat <= 1'h0;
        cyc(3);
        chk("clock held", 1, rco);
        chk("data held", 1, rdo);
        mute_n <= 1'h1;
        cyc(3);
        chk("data free", 0, rdo);
        chk("clock free", 0, rco);
    endtask

    initial begin
        #100000;
        fails++;
        print_verdict();
    end

    initial begin
        cyc(8);
        rst <= 1'h0;
        cyc(2);
        t_reset();
        t_carrier();
        t_request();
        t_auto();
        t_manual();
        t_mute();
        print_verdict();
    end
endmodule

//--- verilog/rss_carrier_oneshot.sv
package rss_pkg;
    // Clock and timing.
    localparam int RSS_CLK_HZ = 100_000_000;
    localparam real RSS_STEP_PERIOD_MS = 10.5;
    localparam int RSS_STEP_PERIOD_CYC = int'(RSS_STEP_PERIOD_MS * RSS_CLK_HZ / 1000.0);
    localparam int RSS_CARRIER_US = 1;
    localparam int RSS_CARRIER_CYC = RSS_CARRIER_US * (RSS_CLK_HZ / 1_000_000);
    localparam int RSS_CARRIER_W = 7;
    localparam int RSS_PERIOD_W = 24;
    localparam int RSS_RATE_COUNT = 4;

    // Register byte addresses.
    localparam logic [4:0] RSS_ADDR_CTRL = 5'h00;
    localparam logic [4:0] RSS_ADDR_STATUS = 5'h04;
    localparam logic [4:0] RSS_ADDR_PERIOD = 5'h08;
    localparam logic [4:0] RSS_ADDR_IRQ_STATUS = 5'h0C;
    localparam logic [4:0] RSS_ADDR_IRQ_MASK = 5'h10;

    // Field positions.
    localparam int RSS_CTRL_STEP_EN = 0;
    localparam int RSS_STAT_RATE_LO = 0;
    localparam int RSS_STAT_PRESENT = 2;
    localparam int RSS_STAT_REQUEST = 3;
    localparam int RSS_STAT_AUTO = 4;
    localparam int RSS_IRQ_STEP = 0;
    localparam int RSS_IRQ_LOST = 1;
    localparam int RSS_IRQ_FOUND = 2;
    localparam int RSS_IRQ_LOCK = 3;

    // Reset values.
    localparam logic RSS_CTRL_RESET = 1'h1;
    localparam logic [1:0] RSS_RATE_RESET = 2'h0;
    localparam logic [3:0] RSS_IRQ_MASK_RESET = 4'h0;

    typedef enum logic {
        RSS_BUS_IDLE = 1'b0,
        RSS_BUS_ACK = 1'b1
    } rss_bus_state_type;

    function automatic logic [1:0] rss_rate_inc(input logic [1:0] rate);
        rss_rate_inc = rate + 2'h1;
    endfunction

    function automatic logic [31:0] rss_be_merge(input logic [31:0] old,
                                                 input logic [31:0] wdata,
                                                 input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = wdata[i*8 +: 8];
            end
        end
        rss_be_merge = res;
    endfunction
endpackage

module rss_carrier_oneshot
    import rss_pkg::*;
(
    input wire logic clk_sys, // System clock.
    input wire logic rst, // Synchronous reset, active high.
    input wire logic clk_en, // Freezes all state while low.
    input wire logic data_in, // Serial data sample.
    output logic present_out // Data transitions seen recently.
);
    typedef struct packed {
        logic prev_data;
        logic [RSS_CARRIER_W-1:0] count;
        logic present;
    } rss_shot_state_type;

    rss_shot_state_type st_reg;
    rss_shot_state_type st_next;

    always_comb begin
        st_next = st_reg;
        st_next.prev_data = data_in;
        if (data_in != st_reg.prev_data) begin
            st_next.count = RSS_CARRIER_W'(RSS_CARRIER_CYC);
        end else if (st_reg.count != '0) begin
            st_next.count = st_reg.count - 1'b1;
        end
        st_next.present = (st_next.count != '0);
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_reg <= '0;
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    assign present_out = st_reg.present;

    a_shot_retrigger: assert property (@(posedge clk_sys) disable iff (rst)
        clk_en && (data_in != st_reg.prev_data)
        |=> present_out && st_reg.count == RSS_CARRIER_W'(RSS_CARRIER_CYC))
        else $error("carrier one-shot did not retrigger on a data edge");
endmodule

//--- verilog/rss_rate_search_unit.sv
// Local design decisions: the address map and the Avalon-MM slave port.
module rss_rate_search_unit
    import rss_pkg::*;
#(
    parameter int STEP_PERIOD_CYC = RSS_STEP_PERIOD_CYC
)
(
    input wire logic clk_sys, // System clock, 100 MHz.
    input wire logic rst, // Synchronous reset, active high.
    input wire logic clk_en, // Freezes all state while low.
    input wire logic [4:0] avs_address, // Byte address.
    input wire logic avs_read, // Read request.
    input wire logic avs_write, // Write request.
    input wire logic [31:0] avs_writedata, // Write data.
    input wire logic [3:0] avs_byteenable, // Byte lanes.
    output logic [31:0] avs_readdata, // Read data.
    output logic avs_waitrequest, // Holds the master off.
    input wire logic auto_mode, // High selects automatic rate search.
    input wire logic search_latch_enable, // Step enable and index latch.
    input wire logic mute_n, // Low holds clock and data outputs.
    input wire logic serial_data_in, // Serial input data sample.
    input wire logic freq_unlock_flag, // Frequency detector active.
    input wire logic harmonic_lock_flag, // Loop locked on a harmonic.
    input wire logic recovered_clock_in, // Clock from the loop.
    input wire logic retimed_data_in, // Data from the retiming latch.
    input wire logic rate_bit_low_in, // Rate bus bit 0, pin level.
    output logic rate_bit_low_out, // Rate bus bit 0, driven value.
    output logic rate_bit_low_oe, // Rate bus bit 0, drive enable.
    input wire logic rate_bit_high_in, // Rate bus bit 1, pin level.
    output logic rate_bit_high_out, // Rate bus bit 1, driven value.
    output logic rate_bit_high_oe, // Rate bus bit 1, drive enable.
    output logic recovered_clock_out, // Clock, held while muted.
    output logic retimed_data_out, // Data, held while muted.
    output logic signal_present, // Carrier detect.
    output logic search_request, // Request for a rate search.
    output logic irq // Level interrupt.
);
    typedef struct packed {
        rss_bus_state_type bus_state;
        logic waitreq;
        logic [31:0] rdata;
        logic step_en;
        logic [RSS_PERIOD_W-1:0] period;
        logic [RSS_PERIOD_W-1:0] tick;
        logic [1:0] rate;
        logic rate_oe;
        logic present;
        logic request;
        logic clock_out;
        logic data_out;
        logic [3:0] irq_status;
        logic [3:0] irq_mask;
        logic irq;
    } rss_state_type;

    rss_state_type st_reg;
    rss_state_type st_next;
    rss_state_type st_reset;

    logic shot_present;
    logic stepping;
    logic step_now;
    logic [1:0] pin_rate;
    logic [3:0] irq_set;
    logic [3:0] irq_clr;
    logic bus_req;
    logic wr_now;
    logic [31:0] rd_mux;

    rss_carrier_oneshot u_carrier (
        .clk_sys(clk_sys),
        .rst(rst),
        .clk_en(clk_en),
        .data_in(serial_data_in),
        .present_out(shot_present)
    );

    always_comb begin
        st_reset = '0;
        st_reset.bus_state = RSS_BUS_IDLE;
        st_reset.waitreq = 1'b1;
        st_reset.step_en = RSS_CTRL_RESET;
        st_reset.period = RSS_PERIOD_W'(STEP_PERIOD_CYC);
        st_reset.rate = RSS_RATE_RESET;
        st_reset.irq_mask = RSS_IRQ_MASK_RESET;
    end

    assign pin_rate = {rate_bit_high_in, rate_bit_low_in};
    assign bus_req = avs_read | avs_write;
    // A write lands at the edge on which the master sees waitrequest low.
    assign wr_now = (st_reg.bus_state == RSS_BUS_ACK) && avs_write;

    // The loop pins the search on the oscillator through the latch enable;
    // a missing carrier blocks it whatever the latch enable does.
    assign stepping = auto_mode && search_latch_enable && st_reg.present
        && st_reg.step_en;
    assign step_now = stepping && (st_reg.tick >= st_reg.period - 1'b1);

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (avs_address)
            RSS_ADDR_CTRL: rd_mux[RSS_CTRL_STEP_EN] = st_reg.step_en;
            RSS_ADDR_STATUS: begin
                rd_mux[RSS_STAT_RATE_LO +: 2] = st_reg.rate;
                rd_mux[RSS_STAT_PRESENT] = st_reg.present;
                rd_mux[RSS_STAT_REQUEST] = st_reg.request;
                rd_mux[RSS_STAT_AUTO] = st_reg.rate_oe;
            end
            RSS_ADDR_PERIOD: rd_mux[RSS_PERIOD_W-1:0] = st_reg.period;
            RSS_ADDR_IRQ_STATUS: rd_mux[3:0] = st_reg.irq_status;
            RSS_ADDR_IRQ_MASK: rd_mux[3:0] = st_reg.irq_mask;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_comb begin
        st_next = st_reg;
        irq_set = 4'h0;
        irq_clr = 4'h0;

        // Bus slave: one wait cycle, then a single answer cycle.
        case (st_reg.bus_state)
            RSS_BUS_IDLE: begin
                if (bus_req) begin
                    st_next.bus_state = RSS_BUS_ACK;
                    st_next.waitreq = 1'b0;
                    st_next.rdata = rd_mux;
                end
            end
            RSS_BUS_ACK: begin
                st_next.bus_state = RSS_BUS_IDLE;
                st_next.waitreq = 1'b1;
            end
            default: begin
                st_next.bus_state = RSS_BUS_IDLE;
                st_next.waitreq = 1'b1;
            end
        endcase

        if (wr_now) begin
            case (avs_address)
                RSS_ADDR_CTRL: begin
                    if (avs_byteenable[0]) begin
                        st_next.step_en = avs_writedata[RSS_CTRL_STEP_EN];
                    end
                end
                RSS_ADDR_PERIOD: begin
                    st_next.period = RSS_PERIOD_W'(rss_be_merge(32'(st_reg.period),
                        avs_writedata, avs_byteenable));
                end
                RSS_ADDR_IRQ_STATUS: begin
                    if (avs_byteenable[0]) begin
                        irq_clr = avs_writedata[3:0];
                    end
                end
                RSS_ADDR_IRQ_MASK: begin
                    st_next.irq_mask = 4'(rss_be_merge(32'(st_reg.irq_mask),
                        avs_writedata, avs_byteenable));
                end
                default: begin
                end
            endcase
        end

        // Carrier detect and search request.
        st_next.present = shot_present;
        // The loop clock and retimed data do not feed the request, which is only the
        // carrier gate and the flags; the analog detectors have already folded them into the flags.
        st_next.request = shot_present
            && (freq_unlock_flag || harmonic_lock_flag);

        // Step oscillator and rate index.
        if (!stepping) begin
            st_next.tick = '0;
        end else if (step_now) begin
            st_next.tick = '0;
        end else begin
            st_next.tick = st_reg.tick + 1'b1;
        end
        if (!auto_mode && search_latch_enable) begin
            st_next.rate = pin_rate;
        end else if (step_now) begin
            st_next.rate = rss_rate_inc(st_reg.rate);
            irq_set[RSS_IRQ_STEP] = 1'b1;
        end

        // Rate bus drive: both lines follow the mode pin together.
        st_next.rate_oe = auto_mode;

        // Output hold while muted.
        if (mute_n) begin
            st_next.clock_out = recovered_clock_in;
            st_next.data_out = retimed_data_in;
        end else begin
            st_next.clock_out = st_reg.clock_out;
            st_next.data_out = st_reg.data_out;
        end

        irq_set[RSS_IRQ_LOST] = st_reg.present && !shot_present;
        irq_set[RSS_IRQ_FOUND] = !st_reg.present && shot_present;
        irq_set[RSS_IRQ_LOCK] = st_reg.request && !st_next.request;
        // A new event outranks a clear written in the same cycle.
        st_next.irq_status = (st_reg.irq_status & ~irq_clr) | irq_set;
        st_next.irq = |(st_next.irq_status & st_next.irq_mask);
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_reg <= st_reset;
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    assign avs_readdata = st_reg.rdata;
    assign avs_waitrequest = st_reg.waitreq;
    assign rate_bit_low_out = st_reg.rate[0];
    assign rate_bit_high_out = st_reg.rate[1];
    assign rate_bit_low_oe = st_reg.rate_oe;
    assign rate_bit_high_oe = st_reg.rate_oe;
    assign recovered_clock_out = st_reg.clock_out;
    assign retimed_data_out = st_reg.data_out;
    assign signal_present = st_reg.present;
    assign search_request = st_reg.request;
    assign irq = st_reg.irq;

    a_step_wraps_up: assert property (@(posedge clk_sys) disable iff (rst)
        clk_en && step_now && auto_mode |=> st_reg.rate == rss_rate_inc($past(st_reg.rate)))
        else $error("rate index did not advance by one on a step");

    a_step_at_period: assert property (@(posedge clk_sys) disable iff (rst)
        clk_en && step_now |-> st_reg.tick == st_reg.period - 1'b1)
        else $error("rate step came at the wrong tick count");

    a_carrier_blocks_step: assert property (@(posedge clk_sys) disable iff (rst)
        clk_en && auto_mode && !st_reg.present |=> $stable(st_reg.rate))
        else $error("rate index moved with no carrier");

    a_bus_drive_auto: assert property (@(posedge clk_sys) disable iff (rst)
        clk_en && auto_mode |=> rate_bit_low_oe && rate_bit_high_oe)
        else $error("rate bus not driven in automatic mode");

    a_bus_float_manual: assert property (@(posedge clk_sys) disable iff (rst)
        clk_en && !auto_mode |=> !rate_bit_low_oe && !rate_bit_high_oe)
        else $error("rate bus driven in manual mode");

    a_manual_latch_index: assert property (@(posedge clk_sys) disable iff (rst)
        clk_en && !auto_mode && search_latch_enable
        |=> {rate_bit_high_out, rate_bit_low_out} == $past(pin_rate))
        else $error("manual index not latched from the rate bus");

    a_request_gating: assert property (@(posedge clk_sys) disable iff (rst)
        clk_en && search_request |-> ##0 $past(shot_present))
        else $error("search request raised without carrier");

    a_mute_holds_out: assert property (@(posedge clk_sys) disable iff (rst)
        clk_en && !mute_n |=> $stable(recovered_clock_out) && $stable(retimed_data_out))
        else $error("outputs moved while muted");

    a_irq_step_sticky: assert property (@(posedge clk_sys) disable iff (rst)
        clk_en && step_now |=> st_reg.irq_status[RSS_IRQ_STEP])
        else $error("step event not recorded");

    // The step oscillator only counts while the search is enabled.
    a_no_early_step: assert property (@(posedge clk_sys) disable iff (rst)
        clk_en && stepping && st_reg.tick < st_reg.period - 1'b1
        |=> st_reg.rate == $past(st_reg.rate))
        else $error("rate index stepped before the period ended");

    a_tick_counts_up: assert property (@(posedge clk_sys) disable iff (rst)
        clk_en && stepping && !step_now |=> st_reg.tick == $past(st_reg.tick) + 1'b1)
        else $error("step oscillator did not count");

    a_tick_clears_idle: assert property (@(posedge clk_sys) disable iff (rst)
        clk_en && !stepping |=> st_reg.tick == '0)
        else $error("step oscillator kept counting while idle");

    a_wrap_to_zero: assert property (@(posedge clk_sys) disable iff (rst)
        clk_en && step_now && st_reg.rate == 2'h3 |=> st_reg.rate == 2'h0)
        else $error("rate index did not wrap from three to zero");

    a_enable_gates_step: assert property (@(posedge clk_sys) disable iff (rst)
        clk_en && auto_mode && !search_latch_enable |=> st_reg.rate == $past(st_reg.rate))
        else $error("rate index moved with the latch enable low");

    a_manual_holds_index: assert property (@(posedge clk_sys) disable iff (rst)
        clk_en && !auto_mode && !search_latch_enable |=> st_reg.rate == $past(st_reg.rate))
        else $error("manual index moved without a latch pulse");

    // Request and carrier checks look one edge ahead, as both outputs are registered.
    a_request_on_unlock: assert property (@(posedge clk_sys) disable iff (rst)
        clk_en && shot_present && freq_unlock_flag |=> search_request)
        else $error("frequency unlock with carrier raised no request");

    a_request_on_harmonic: assert property (@(posedge clk_sys) disable iff (rst)
        clk_en && shot_present && harmonic_lock_flag |=> search_request)
        else $error("harmonic lock with carrier raised no request");

    a_request_drops_lock: assert property (@(posedge clk_sys) disable iff (rst)
        clk_en && !freq_unlock_flag && !harmonic_lock_flag |=> !search_request)
        else $error("request stayed up after lock");

    a_present_follows: assert property (@(posedge clk_sys) disable iff (rst)
        clk_en |=> signal_present == $past(shot_present))
        else $error("carrier detect output did not follow the one-shot");

    a_lost_sticky: assert property (@(posedge clk_sys) disable iff (rst)
        clk_en && st_reg.present && !shot_present |=> st_reg.irq_status[RSS_IRQ_LOST])
        else $error("carrier loss not recorded");

    a_found_sticky: assert property (@(posedge clk_sys) disable iff (rst)
        clk_en && !st_reg.present && shot_present |=> st_reg.irq_status[RSS_IRQ_FOUND])
        else $error("carrier arrival not recorded");

    a_lock_sticky: assert property (@(posedge clk_sys) disable iff (rst)
        clk_en && st_reg.request && !st_next.request |=> st_reg.irq_status[RSS_IRQ_LOCK])
        else $error("falling request not recorded");

    // Mute high lets the loop outputs through with one register of delay.
    a_mute_passes_through: assert property (@(posedge clk_sys) disable iff (rst)
        clk_en && mute_n |=> recovered_clock_out == $past(recovered_clock_in)
        && retimed_data_out == $past(retimed_data_in))
        else $error("outputs did not follow the loop while unmuted");
endmodule
